// ==== hw/dpwu_pkg.sv ====
// constants, field layouts and carrier types for the direct pixel write unpacker
package dpwu_pkg;

  // register offsets (byte addresses on the register port)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_DIRECT_WRITE_CONTROL = 8'h00;
  localparam logic [7:0] OFS_DEPTH_BUFFER_MODE_CONTROL = 8'h04;
  localparam logic [7:0] OFS_RENDER_FORMAT_CONTROL = 8'h08;
  localparam logic [7:0] OFS_CONSTANT_COLOUR_ONE = 8'h0C;
  localparam logic [7:0] OFS_CONSTANT_DEPTH_ALPHA = 8'h10;
  localparam logic [7:0] OFS_SCREEN_HEIGHT = 8'h14;
  localparam logic [7:0] OFS_WRITE_STATUS = 8'h18;

  // reset values
  localparam logic [31:0] RST_REG32 = 32'h0000_0000;
  localparam logic [10:0] RST_SCREEN_HEIGHT = 11'h1E0;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  // direct_write_control fields
  localparam int DWC_FMT_LSB = 0;
  localparam int DWC_PIPE_BIT = 8;
  localparam int DWC_LANE_LSB = 9;
  localparam int DWC_WSWAP_BIT = 11;
  localparam int DWC_SWIZZLE_BIT = 12;
  localparam int DWC_YORG_BIT = 13;
  localparam int DWC_WSEL_BIT = 14;
  // depth_buffer_mode_control field
  localparam int DBM_YORG_BIT = 17;
  // render_format_control fields
  localparam int RFC_MODE_LSB = 0;
  localparam int RFC_ASRC_LSB = 15;
  localparam logic [1:0] RFC_MODE_15BPP = 2'h1;
  localparam logic [1:0] RFC_MODE_32BPP = 2'h2;
  // constant depth/alpha layout
  localparam int CDA_ALPHA_LSB = 24;

  // direct-write format codes
  localparam logic [3:0] FMT_RGB565 = 4'h0;
  localparam logic [3:0] FMT_XRGB1555 = 4'h1;
  localparam logic [3:0] FMT_ARGB1555 = 4'h2;
  localparam logic [3:0] FMT_XRGB8888 = 4'h4;
  localparam logic [3:0] FMT_ARGB8888 = 4'h5;
  localparam logic [3:0] FMT_DEPTH32 = 4'h8;
  localparam logic [3:0] FMT_Z16_RGB565 = 4'hC;
  localparam logic [3:0] FMT_Z16_XRGB1555 = 4'hD;
  localparam logic [3:0] FMT_Z16_ARGB1555 = 4'hE;
  localparam logic [3:0] FMT_Z16_Z16 = 4'hF;

  typedef struct packed {
    logic valid;
    logic [10:0] x;
    logic [10:0] y;
    logic [31:0] data;
  } dpwu_host_wr_type;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    logic [7:0] a;
  } dpwu_rgba_type;

  typedef struct packed {
    logic valid;
    logic pipe;
    logic col_we;
    logic z_we;
    logic a_we;
    logic [10:0] x;
    logic [10:0] y;
    dpwu_rgba_type col;
    logic [31:0] z;
    logic [47:0] w;
  } dpwu_pix_type;

endpackage : dpwu_pkg

// ==== hw/dpwu_unpacker.sv ====
// direct pixel write unpacker: register port, word unpacking and pixel output
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/10ps

module dpwu_unpacker
  import dpwu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire dpwu_host_wr_type host_wr,
  output dpwu_pix_type pix_left,
  output dpwu_pix_type pix_right
);

  typedef struct packed {
    logic [31:0] direct_write_control_reg;
    logic [31:0] depth_buffer_mode_control_reg;
    logic [31:0] render_format_control_reg;
    logic [31:0] constant_colour_one_reg;
    logic [31:0] constant_depth_alpha_reg;
    logic [10:0] screen_height_reg;
    logic [15:0] accepted_count_reg;
    logic [15:0] discard_count_reg;
    logic [31:0] rdata_reg;
    dpwu_pix_type left_reg;
    dpwu_pix_type right_reg;
  } dpwu_state_type;

  dpwu_state_type state_reg;
  dpwu_state_type state_next;

  function automatic logic [7:0] dpwu_expand5(input logic [4:0] v);
    dpwu_expand5 = {v, v[4:2]};
  endfunction : dpwu_expand5

  function automatic logic [7:0] dpwu_expand6(input logic [5:0] v);
    dpwu_expand6 = {v, v[5:4]};
  endfunction : dpwu_expand6

  // decode one 16-bit colour half; code is the colour part of the format (0, 1 or 2)
  function automatic dpwu_rgba_type dpwu_decode16(input logic [15:0] h, input logic [1:0] code,
                                                  input logic [1:0] lane);
    logic [7:0] c0;
    logic [7:0] c1;
    dpwu_rgba_type o;
    c0 = 8'h00;
    c1 = 8'h00;
    o = '0;
    if (code == 2'd0) begin
      c0 = dpwu_expand5(h[15:11]);
      o.g = dpwu_expand6(h[10:5]);
      c1 = dpwu_expand5(h[4:0]);
    end else if (!lane[1]) begin
      c0 = dpwu_expand5(h[14:10]);
      o.g = dpwu_expand5(h[9:5]);
      c1 = dpwu_expand5(h[4:0]);
      o.a = {8{h[15]}};
    end else begin
      c0 = dpwu_expand5(h[15:11]);
      o.g = dpwu_expand5(h[10:6]);
      c1 = dpwu_expand5(h[5:1]);
      o.a = {8{h[0]}};
    end
    // lane bit 0 swaps red and blue
    o.r = lane[0] ? c1 : c0;
    o.b = lane[0] ? c0 : c1;
    dpwu_decode16 = o;
  endfunction : dpwu_decode16

  // decode one 32-bit colour word (formats 4 and 5)
  function automatic dpwu_rgba_type dpwu_decode32(input logic [31:0] w, input logic [1:0] lane);
    logic [7:0] c0;
    logic [7:0] c1;
    dpwu_rgba_type o;
    o = '0;
    // upper lanes take alpha from the low byte, lower lanes from the top byte
    // alpha byte follows the lane choice
    if (!lane[1]) begin
      o.a = w[31:24];
      c0 = w[23:16];
      o.g = w[15:8];
      c1 = w[7:0];
    end else begin
      c0 = w[31:24];
      o.g = w[23:16];
      c1 = w[15:8];
      o.a = w[7:0];
    end
    o.r = lane[0] ? c1 : c0;
    o.b = lane[0] ? c0 : c1;
    dpwu_decode32 = o;
  endfunction : dpwu_decode32

  // 16-bit depth widened to the buffer depth; 32-bit mode replicates the top byte
  function automatic logic [31:0] dpwu_depth16(input logic [15:0] z, input logic deep);
    dpwu_depth16 = deep ? {8'h00, z, z[15:8]} : {16'h0000, z};
  endfunction : dpwu_depth16

  logic [31:0] dwc;
  logic [31:0] cda;
  logic [3:0] fmt;
  logic [1:0] lane;
  logic pipe;
  logic deep;
  logic [31:0] swz_word;
  logic [31:0] word;
  logic fmt_ok;
  logic has_alpha;
  logic has_colour;
  logic has_depth;
  logic two_pix;
  logic y_bottom;
  logic [10:0] y_out;
  logic [7:0] fill_alpha;
  dpwu_rgba_type col_l;
  dpwu_rgba_type col_r;
  logic [31:0] z_l;
  logic [31:0] z_r;

  always_comb begin
    dwc = state_reg.direct_write_control_reg;
    cda = state_reg.constant_depth_alpha_reg;
    fmt = dwc[DWC_FMT_LSB +: 4];
    lane = dwc[DWC_LANE_LSB +: 2];
    pipe = dwc[DWC_PIPE_BIT];
    deep = state_reg.render_format_control_reg[RFC_MODE_LSB +: 2] == RFC_MODE_32BPP;
    // swizzle comes first, on every format
    swz_word = dwc[DWC_SWIZZLE_BIT] ? {host_wr.data[7:0], host_wr.data[15:8],
                                       host_wr.data[23:16], host_wr.data[31:24]} : host_wr.data;
    // word swap acts on the swizzled word
    if (dwc[DWC_WSWAP_BIT] && fmt != FMT_XRGB8888 && fmt != FMT_ARGB8888 && fmt != FMT_DEPTH32) begin
      word = {swz_word[15:0], swz_word[31:16]};
    end else begin
      word = swz_word;
    end
    has_alpha = 1'b0;
    has_colour = 1'b1;
    has_depth = 1'b0;
    two_pix = 1'b0;
    fmt_ok = 1'b1;
    col_l = '0;
    col_r = '0;
    z_l = {8'h00, cda[23:0]};
    z_r = {8'h00, cda[23:0]};
    // lanes picked last, from the swapped word
    unique case (fmt)
      FMT_RGB565, FMT_XRGB1555, FMT_ARGB1555: begin
        // after the swap, right is upper and left lower
        col_l = dpwu_decode16(word[15:0], fmt[1:0], lane);
        col_r = dpwu_decode16(word[31:16], fmt[1:0], lane);
        has_alpha = fmt == FMT_ARGB1555;
        two_pix = 1'b1;
      end
      FMT_XRGB8888, FMT_ARGB8888: begin
        col_l = dpwu_decode32(word, lane);
        has_alpha = fmt == FMT_ARGB8888;
      end
      FMT_DEPTH32: begin
        col_l = state_reg.constant_colour_one_reg[31:0];
        col_l.a = cda[CDA_ALPHA_LSB +: 8];
        // depth taken as supplied, already encoded
        z_l = word;
        has_colour = 1'b0;
        has_depth = 1'b1;
      end
      FMT_Z16_RGB565, FMT_Z16_XRGB1555, FMT_Z16_ARGB1555: begin
        col_l = dpwu_decode16(word[15:0], fmt[1:0], lane);
        z_l = dpwu_depth16(word[31:16], deep);
        has_alpha = fmt == FMT_Z16_ARGB1555;
        has_depth = 1'b1;
      end
      FMT_Z16_Z16: begin
        // swap set puts left depth in the upper half
        z_l = dpwu_depth16(word[15:0], deep);
        z_r = dpwu_depth16(word[31:16], deep);
        col_l = state_reg.constant_colour_one_reg[31:0];
        col_l.a = cda[CDA_ALPHA_LSB +: 8];
        col_r = col_l;
        has_colour = 1'b0;
        has_depth = 1'b1;
        two_pix = 1'b1;
      end
      default: begin
        fmt_ok = 1'b0;
      end
    endcase
    // pipeline depth-only format 15 copies the left pixel's constant colour to the right pixel as well
    if (fmt == FMT_Z16_Z16 && pipe) begin
      col_r = col_l;
    end
    unique case (state_reg.render_format_control_reg[RFC_ASRC_LSB +: 2])
      2'd0: fill_alpha = 8'h00;
      2'd1: fill_alpha = 8'hFF;
      2'd2: fill_alpha = {8{cda[31]}};
      default: fill_alpha = 8'h00;
    endcase
    if (!has_alpha && has_colour) begin
      // pipeline takes alpha from the constant register
      col_l.a = pipe ? cda[CDA_ALPHA_LSB +: 8] : fill_alpha;
      col_r.a = col_l.a;
    end
    // bypass uses the direct-write origin bit
    // pipeline uses the depth-mode origin bit
    y_bottom = pipe ? state_reg.depth_buffer_mode_control_reg[DBM_YORG_BIT] : dwc[DWC_YORG_BIT];
    y_out = y_bottom ? 11'(state_reg.screen_height_reg - 11'd1 - host_wr.y) : host_wr.y;
  end

  always_comb begin
    state_next = state_reg;
    state_next.rdata_reg = RST_REG32;
    state_next.left_reg.valid = 1'b0;
    state_next.right_reg.valid = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_DIRECT_WRITE_CONTROL: state_next.direct_write_control_reg = reg_wdata;
        OFS_DEPTH_BUFFER_MODE_CONTROL: state_next.depth_buffer_mode_control_reg = reg_wdata;
        OFS_RENDER_FORMAT_CONTROL: state_next.render_format_control_reg = reg_wdata;
        OFS_CONSTANT_COLOUR_ONE: state_next.constant_colour_one_reg = reg_wdata;
        OFS_CONSTANT_DEPTH_ALPHA: state_next.constant_depth_alpha_reg = reg_wdata;
        OFS_SCREEN_HEIGHT: state_next.screen_height_reg = reg_wdata[10:0];
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_DIRECT_WRITE_CONTROL: state_next.rdata_reg = state_reg.direct_write_control_reg;
        OFS_DEPTH_BUFFER_MODE_CONTROL: state_next.rdata_reg = state_reg.depth_buffer_mode_control_reg;
        OFS_RENDER_FORMAT_CONTROL: state_next.rdata_reg = state_reg.render_format_control_reg;
        OFS_CONSTANT_COLOUR_ONE: state_next.rdata_reg = state_reg.constant_colour_one_reg;
        OFS_CONSTANT_DEPTH_ALPHA: state_next.rdata_reg = state_reg.constant_depth_alpha_reg;
        OFS_SCREEN_HEIGHT: state_next.rdata_reg = {21'h0, state_reg.screen_height_reg};
        OFS_WRITE_STATUS: state_next.rdata_reg = {state_reg.discard_count_reg, state_reg.accepted_count_reg};
        default: state_next.rdata_reg = RST_REG32;
      endcase
    end
    if (host_wr.valid) begin
      if (fmt_ok) begin
        state_next.accepted_count_reg = state_reg.accepted_count_reg + 16'd1;
        state_next.left_reg.valid = 1'b1;
        state_next.left_reg.pipe = pipe;
        state_next.left_reg.x = host_wr.x;
        state_next.left_reg.y = y_out;
        state_next.left_reg.col = col_l;
        state_next.left_reg.z = z_l;
        // bypass touches the buffers the format carries, plus alpha for any colour format in 15bpp mode
        state_next.left_reg.col_we = pipe | has_colour;
        state_next.left_reg.z_we = pipe | has_depth;
        state_next.left_reg.a_we = pipe | has_alpha |
                                   (has_colour && state_reg.render_format_control_reg[1:0] == RFC_MODE_15BPP);
        // W fraction MSBs from Z or the constant depth
        // the rest of W is zero; bypass gives zero
        state_next.left_reg.w = '0;
        if (pipe) begin
          state_next.left_reg.w[31:16] = dwc[DWC_WSEL_BIT] ? cda[23:8] : (deep || fmt == FMT_DEPTH32 ||
                                         !has_depth) ? z_l[23:8] : z_l[15:0];
        end
        state_next.right_reg = state_next.left_reg;
        state_next.right_reg.valid = two_pix;
        state_next.right_reg.x = 11'(host_wr.x + 11'd1);
        state_next.right_reg.col = col_r;
        state_next.right_reg.z = z_r;
        if (pipe) begin
          state_next.right_reg.w[31:16] = dwc[DWC_WSEL_BIT] ? cda[23:8] : (deep || !has_depth) ?
                                          z_r[23:8] : z_r[15:0];
        end
      end else begin
        state_next.discard_count_reg = state_reg.discard_count_reg + 16'd1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.screen_height_reg <= RST_SCREEN_HEIGHT;
      state_reg.accepted_count_reg <= RST_COUNT;
      state_reg.discard_count_reg <= RST_COUNT;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata_reg;
  assign pix_left = state_reg.left_reg;
  assign pix_right = state_reg.right_reg;

endmodule : dpwu_unpacker

// ==== testbench/dpwu_unpacker_properties.sv ====
// port assertions for the direct pixel write unpacker
`timescale 1ns/10ps
module dpwu_unpacker_properties
  import dpwu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire dpwu_host_wr_type host_wr,
  input wire dpwu_pix_type pix_left,
  input wire dpwu_pix_type pix_right
);
  logic [31:0] ctl_reg;
  logic [31:0] ctl_next;
  logic [3:0] fmt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  assign fmt = ctl_reg[3:0];
  // shadow of the write control, updated on the same edge as the design's copy
  always_comb begin
    ctl_next = ctl_reg;
    if (reg_wr && reg_addr == OFS_DIRECT_WRITE_CONTROL) begin
      ctl_next = reg_wdata;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_reg <= 32'h0000_0000;
    end else begin
      ctl_reg <= ctl_next;
    end
  end
  sequence s_fmt5(logic swz);
    host_wr.valid && fmt == FMT_ARGB8888 && ctl_reg[10:9] == 2'h0 && ctl_reg[12] == swz;
  endsequence
  a_read_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  a_pix_latency: assert property (!host_wr.valid |=> !pix_left.valid && !pix_right.valid)
    else $error("pixel output without a host write");
  a_discard_fmt: assert property (
    host_wr.valid && fmt inside {4'h3, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB} |=> !pix_left.valid)
    else $error("unsupported format produced a pixel");
  a_no_word_swap: assert property (s_fmt5(1'b0) |=> pix_left.col.a == $past(host_wr.data[31:24])
    && pix_left.col.b == $past(host_wr.data[7:0]))
    else $error("format 5 word was half swapped");
  a_swizzle_bytes: assert property (s_fmt5(1'b1) |=> pix_left.col.a == $past(host_wr.data[7:0])
    && pix_left.col.r == $past(host_wr.data[15:8]))
    else $error("byte swizzle wrong");
  a_right_pair: assert property (pix_right.valid |-> pix_left.valid && pix_right.x == pix_left.x + 11'h001)
    else $error("right pixel not beside left pixel");
  a_w_bypass: assert property (pix_left.valid && !pix_left.pipe |-> pix_left.w == 48'h0000_0000_0000)
    else $error("bypass pixel carries nonzero w");
  a_w_fraction: assert property (pix_left.valid && pix_left.pipe |->
    pix_left.w[47:32] == 16'h0000 && pix_left.w[15:0] == 16'h0000)
    else $error("w bits outside the fraction msbs set");
  a_alpha_repl: assert property (host_wr.valid && fmt == FMT_ARGB1555 && ctl_reg[8] |=>
    pix_left.col.a inside {8'h00, 8'hFF})
    else $error("one-bit alpha not replicated");
  a_y_bypass: assert property (host_wr.valid && fmt == FMT_RGB565 && ctl_reg[13:8] == 6'h00 |=>
    pix_left.y == $past(host_wr.y))
    else $error("top origin changed y");
endmodule : dpwu_unpacker_properties

bind dpwu_unpacker dpwu_unpacker_properties i_dpwu_unpacker_properties (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .host_wr(host_wr), .pix_left(pix_left), .pix_right(pix_right));

// ==== testbench/dpwu_host_model.sv ====
// host processor model issuing writes into the pixel window
`timescale 1ns/10ps
module dpwu_host_model
  import dpwu_pkg::*;
(
  input wire logic clk,
  output dpwu_host_wr_type host_wr
);
  initial host_wr = '0;
  task automatic send(input logic [10:0] px, input logic [10:0] py, input logic [31:0] d);
    @(posedge clk);
    host_wr <= '{valid: 1'b1, x: px, y: py, data: d};
    @(posedge clk);
    host_wr.valid <= 1'b0;
    // released data must not look like the last word
    host_wr.data <= ~d;
  endtask : send
endmodule : dpwu_host_model

// ==== testbench/testbench.sv ====
// self-checking bench for the direct pixel write unpacker
`timescale 1ns/10ps
module testbench
  import dpwu_pkg::*;
;
  logic clk;
  logic rst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  dpwu_host_wr_type host_wr;
  dpwu_pix_type pix_left;
  dpwu_pix_type pix_right;
  int mismatches;
  int samples_checked;
  int cycles;
  int acc;
  int disc;
  int fl[8] = '{0, 1, 2, 4, 5, 12, 13, 14};
  int bad[6] = '{3, 6, 7, 9, 10, 11};
  logic [1:0] rmode;
  logic [31:0] lfsr;
  logic [31:0] cda;
  logic [31:0] c;
  logic [31:0] r;
  dpwu_unpacker i_dpwu_unpacker (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_wr(host_wr), .pix_left(pix_left),
    .pix_right(pix_right));
  dpwu_host_model i_dpwu_host_model (.clk(clk), .host_wr(host_wr));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic stop_test();
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask : rd
  // expected {r,g,b,a} of one 16-bit half or one 32-bit word
  function automatic logic [31:0] unpack(input int f, input logic [1:0] ln, input logic [31:0] w);
    logic [7:0] r8;
    logic [7:0] g8;
    logic [7:0] b8;
    logic [7:0] a8;
    logic [4:0] c5;
    logic [4:0] e5;
    logic [5:0] m6;
    a8 = 8'h00;
    m6 = 6'h00;
    if (f > 3) begin
      if (ln[1]) {r8, g8, b8, a8} = w;
      else {a8, r8, g8, b8} = w;
    end else begin
      if (f == 0) {c5, m6, e5} = w[15:0];
      else if (ln[1]) {c5, m6[4:0], e5, a8[0]} = w[15:0];
      else {a8[0], c5, m6[4:0], e5} = w[15:0];
      a8 = {8{a8[0]}};
      r8 = {c5, c5[4:2]};
      b8 = {e5, e5[4:2]};
      g8 = (f == 0) ? {m6, m6[5:4]} : {m6[4:0], m6[4:2]};
    end
    if (ln[0]) {r8, b8} = {b8, r8};
    return {r8, g8, b8, a8};
  endfunction : unpack
  // one host word through the partner, then both pixels against the model
  task automatic px(input logic [31:0] ctl, input logic [10:0] y, input logic [10:0] ey, input logic [7:0] pa,
      input logic [31:0] d);
    int f;
    int g;
    logic ok;
    logic [31:0] w;
    logic [31:0] e;
    logic [3:0] en;
    f = ctl[3:0];
    // depth-plus-colour formats share the colour layout of formats 0 to 2
    g = f inside {12, 13, 14} ? f - 12 : f;
    ok = !(f inside {3, 6, 7, 9, 10, 11});
    w = ctl[12] ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    if (ctl[11] && !(f inside {4, 5, 8}))
      w = {w[15:0], w[31:16]};
    i_dpwu_host_model.send(11'h010, y, d);
    #1;
    if (ok) acc++;
    else disc++;
    check(pix_left.valid, ok);
    check(pix_right.valid, ok && (f < 3 || f == 15));
    if (ok) check(pix_left.y, ey);
    if (ok) check({pix_left.x, pix_right.x}, {11'h010, 11'h011});
    en[3] = ctl[8];
    en[2] = ctl[8] | (f inside {0, 1, 2, 4, 5, 12, 13, 14});
    en[1] = ctl[8] | (f inside {8, 12, 13, 14, 15});
    en[0] = ctl[8] | (f inside {2, 5, 14}) | (f inside {0, 1, 4, 12, 13} && rmode == RFC_MODE_15BPP);
    if (ok) check({pix_left.pipe, pix_left.col_we, pix_left.z_we, pix_left.a_we}, en);
    if (ok && f > 11 && f < 15) check(pix_left.z, {16'h0000, w[31:16]});
    if (ok && f > 11 && f < 15 && ctl[8] && !ctl[14]) check(pix_left.w, {16'h0000, w[31:16], 16'h0000});
    if (f == 8 && ctl[8]) check(pix_left.col, {24'h11_2233, cda[31:24]});
    for (int h = 0; h < 2; h++) begin
      if (ok && g < 6 && (h == 0 || f < 3)) begin
        e = unpack(g, ctl[10:9], h ? {16'h0000, w[31:16]} : w);
        if (!(g inside {2, 5}))
          e[7:0] = pa;
        check(h ? pix_right.col : pix_left.col, e);
      end
    end
  endtask : px
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lfsr = 32'ha1b5_344e;
    cda = 32'h8123_4567;
    rmode = 2'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_SCREEN_HEIGHT, 32'h0000_01E0);
    rd(OFS_DIRECT_WRITE_CONTROL, 32'h0000_0000);
    wr(OFS_CONSTANT_DEPTH_ALPHA, cda);
    wr(OFS_CONSTANT_COLOUR_ONE, 32'h1122_3344);
    rd(OFS_CONSTANT_DEPTH_ALPHA, cda);
    rd(8'h40, 32'h0000_0000);
    for (int i = 0; i < 128; i++) begin
      c = {19'h0, i[3], i[2], i[1:0], 1'b1, 4'h0, 4'(fl[i / 16])};
      wr(OFS_DIRECT_WRITE_CONTROL, c);
      px(c, 11'h020, 11'h020, cda[31:24], rnd());
    end
    // formats the host may not use, sent only to prove discarding
    foreach (bad[i]) begin
      wr(OFS_DIRECT_WRITE_CONTROL, 32'(bad[i]));
      px(32'(bad[i]), 11'h000, 11'h000, 8'h00, rnd());
    end
    for (int k = 0; k < 3; k++) begin
      wr(OFS_RENDER_FORMAT_CONTROL, {15'h0, 2'(k), 13'h0, RFC_MODE_15BPP});
      rmode = RFC_MODE_15BPP;
      wr(OFS_DIRECT_WRITE_CONTROL, 32'h0000_0000);
      px(32'h0000_0000, 11'h005, 11'h005, k == 0 ? 8'h00 : k == 1 ? 8'hFF : {8{cda[31]}}, rnd());
    end
    wr(OFS_RENDER_FORMAT_CONTROL, 32'h0000_0000);
    rmode = 2'h0;
    wr(OFS_DIRECT_WRITE_CONTROL, 32'h0000_2000);
    px(32'h0000_2000, 11'h007, 11'd472, 8'h00, rnd());
    wr(OFS_DIRECT_WRITE_CONTROL, 32'h0000_2100);
    px(32'h0000_2100, 11'h007, 11'h007, cda[31:24], rnd());
    wr(OFS_DEPTH_BUFFER_MODE_CONTROL, 32'h0002_0000);
    px(32'h0000_2100, 11'h007, 11'd472, cda[31:24], rnd());
    wr(OFS_DIRECT_WRITE_CONTROL, 32'h0000_4108);
    px(32'h0000_4108, 11'h007, 11'd472, 8'h00, rnd());
    check(pix_left.w, {16'h0000, cda[23:8], 16'h0000});
    r = rnd();
    wr(OFS_DIRECT_WRITE_CONTROL, 32'h0000_090F);
    px(32'h0000_090F, 11'h007, 11'd472, 8'h00, r);
    check(pix_left.z, {16'h0000, r[31:16]});
    check(pix_right.z, {16'h0000, r[15:0]});
    check(pix_left.w, {16'h0000, r[31:16], 16'h0000});
    rd(OFS_WRITE_STATUS, {disc[15:0], acc[15:0]});
    stop_test();
  end
endmodule : testbench
